// >>> keypad_wake_consts.svh
// register offsets, field positions and reset values of the keypad wake unit
`ifndef KEYPAD_WAKE_CONSTS_SVH
`define KEYPAD_WAKE_CONSTS_SVH

// printed offsets are register indexes; byte address is four times the index
`define KPD_STATUS_CONTROL_IDX 8'h1A
`define KPD_PIN_ENABLE_IDX     8'h1B
`define KPD_ADDR_W             10
`define KPD_STATUS_CONTROL_ADR 10'h068
`define KPD_PIN_ENABLE_ADR     10'h06C

`define KPD_PENDING_BIT        3
`define KPD_ACK_BIT            2
`define KPD_MASK_BIT           1
`define KPD_MODE_BIT           0

`define KPD_STATUS_CONTROL_RST 8'h00
`define KPD_PIN_ENABLE_RST     8'h00

`define KPD_VECTOR_HI          16'hFFE0
`define KPD_VECTOR_LO          16'hFFE1

`endif

// >>> keypad_wake_pkg.sv
// types shared by the keypad wake unit
package keypad_wake_pkg;

    typedef struct packed {
        logic [9:0]  adr;
        logic [31:0] dat;
        logic [3:0]  sel;
        logic        we;
        logic        cyc;
        logic        stb;
    } wb_req_type;

    typedef struct packed {
        logic [31:0] dat;
        logic        ack;
    } wb_rsp_type;

    typedef struct packed {
        logic       vector_fetch;
        logic       in_break;
        logic       break_clear_enable;
        logic       low_power;
    } cpu_ctrl_type;

    typedef enum logic [1:0] {
        REQ_IDLE    = 2'b00,
        REQ_LATCHED = 2'b01,
        REQ_ACKED   = 2'b10
    } req_state_type;

endpackage

// >>> keypad_pin_sync.sv
// two-stage synchronizer for the port a pins
`timescale 1ns/1ns
`default_nettype none

module keypad_pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // reset to high: pins idle high under pullups
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= {WIDTH{1'b1}};
            sync_q <= {WIDTH{1'b1}};
        end else if (ce_i) begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule

`default_nettype wire

// >>> keypad_wake_unit.sv
// keypad wake unit: eight port a pins into one shared interrupt request
//
// Summary of operation
// (R1) eight pin inputs, each with own enable
// (R2) enable bit turns on pin pullup
// (R3) request when enabled pins fall from all-high
// (R4) edge mode: no request if another low
// (R5) level mode: request held while any low
// (R6) level mode: clear needs ack and all high
// (R7) vector fetch acknowledge clears the request
// (R8) writing one to ack bit clears request
// (R9) new falling edge after ack relatches
// (R10) unmasked request goes to cpu, vector FFE0
// (R11) edge mode: ack clears request immediately
// (R12) reset clears request and mode bit
// (R13) pending flag ignores the mask bit
// (R14) enable forces pin to input direction
// (R15) software: mask, enable, ack, unmask
// (R16) software: level mode delays ack after enable
// (R17) software: drive pins high before enabling
// (R18) stays active, unmasked request leaves wait
// (R19) stays active, unmasked request leaves stop
// (R20) in break, ack write ignored unless enabled
// (R21) ack bit always reads zero
// (R22) pins synchronised by two flip-flops
//
// The Wishbone register port was decided locally.
`include "keypad_wake_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module keypad_wake_unit #(
    parameter int PINS = 8
) (
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    input  wire logic                         ce_i,
    input  wire keypad_wake_pkg::wb_req_type  wb_req_i,
    output keypad_wake_pkg::wb_rsp_type       wb_rsp_o,
    input  wire keypad_wake_pkg::cpu_ctrl_type cpu_ctrl_i,
    input  wire logic [PINS-1:0]              port_a_pins_i,
    input  wire logic [PINS-1:0]              port_a_direction_i,
    output logic      [PINS-1:0]              port_a_direction_eff_o,
    output logic      [PINS-1:0]              pullup_enable_o,
    output logic                              irq_request_o,
    output logic                              wake_o
);

    ////////////////////////////////////////////////////////////////////////
    // registers

    logic [PINS-1:0] pin_irq_enables_q;
    logic            request_mask_q;
    logic            level_sense_select_q;
    logic            ack_q;
    logic [31:0]     rdat_q;
    logic [PINS-1:0] pins_sync;
    logic            all_high_q;
    logic            request_q;
    keypad_wake_pkg::req_state_type state_q;
    keypad_wake_pkg::req_state_type state_d;

    function automatic logic hit(input logic [9:0] adr, input logic [9:0] ref_adr);
        hit = (adr[9:2] == ref_adr[9:2]);
    endfunction

    logic bus_go;
    logic wr_sc;
    logic wr_en;
    assign bus_go = wb_req_i.cyc && wb_req_i.stb && !ack_q;
    assign wr_sc  = bus_go && wb_req_i.we && wb_req_i.sel[0]
                    && hit(wb_req_i.adr, `KPD_STATUS_CONTROL_ADR);
    assign wr_en  = bus_go && wb_req_i.we && wb_req_i.sel[0]
                    && hit(wb_req_i.adr, `KPD_PIN_ENABLE_ADR);

    ////////////////////////////////////////////////////////////////////////
    // wishbone slave: one registered ack, one wait state, unmapped reads zero

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else if (ce_i) begin
            ack_q <= bus_go;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_q <= 32'h00000000;
        end else if (ce_i && bus_go) begin
            rdat_q <= 32'h00000000;
            if (hit(wb_req_i.adr, `KPD_STATUS_CONTROL_ADR)) begin
                // (R13) pending flag independent of mask
                rdat_q[`KPD_PENDING_BIT] <= request_q;
                // (R21) ack bit reads zero
                rdat_q[`KPD_ACK_BIT]     <= 1'b0;
                rdat_q[`KPD_MASK_BIT]    <= request_mask_q;
                rdat_q[`KPD_MODE_BIT]    <= level_sense_select_q;
            end else if (hit(wb_req_i.adr, `KPD_PIN_ENABLE_ADR)) begin
                rdat_q[PINS-1:0] <= pin_irq_enables_q;
            end
        end
    end

    assign wb_rsp_o.ack = ack_q;
    assign wb_rsp_o.dat = rdat_q;

    ////////////////////////////////////////////////////////////////////////
    // control register and enables

    always_ff @(posedge clk_i) begin
        // (R12) reset clears mode bit
        if (rst_i) begin
            request_mask_q       <= 1'b0;
            level_sense_select_q <= 1'b0;
        end else if (ce_i && wr_sc) begin
            request_mask_q       <= wb_req_i.dat[`KPD_MASK_BIT];
            level_sense_select_q <= wb_req_i.dat[`KPD_MODE_BIT];
        end
    end

    // (R1) per-pin enable register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_irq_enables_q <= `KPD_PIN_ENABLE_RST;
        end else if (ce_i && wr_en) begin
            pin_irq_enables_q <= wb_req_i.dat[PINS-1:0];
        end
    end

    // (R2) pullup follows enable
    assign pullup_enable_o = pin_irq_enables_q;

    // (R14) enable forces input direction
    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_dir
            assign port_a_direction_eff_o[g] = port_a_direction_i[g] && !pin_irq_enables_q[g];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // pin sampling and request latch

    // (R22) two-flop synchroniser
    keypad_pin_sync #(
        .WIDTH (PINS)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .async_i (port_a_pins_i),
        .sync_o  (pins_sync)
    );

    logic any_low;
    logic fall;
    logic ack_evt;
    // (R3) disabled pins ignored
    assign any_low = |(~pins_sync & pin_irq_enables_q);
    // (R4) edge only from all-high state
    assign fall    = any_low && all_high_q;
    // (R7) (R8) (R20) vector fetch or permitted write
    assign ack_evt = cpu_ctrl_i.vector_fetch
                     || (wr_sc && wb_req_i.dat[`KPD_ACK_BIT]
                         && (!cpu_ctrl_i.in_break || cpu_ctrl_i.break_clear_enable));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            all_high_q <= 1'b1;
        end else if (ce_i) begin
            all_high_q <= !any_low;
        end
    end

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            keypad_wake_pkg::REQ_IDLE: begin
                if (fall) begin
                    state_d = keypad_wake_pkg::REQ_LATCHED;
                end
            end
            keypad_wake_pkg::REQ_LATCHED: begin
                if (ack_evt) begin
                    // (R11) edge mode clears at once
                    if (!level_sense_select_q || !any_low) begin
                        state_d = keypad_wake_pkg::REQ_IDLE;
                    end else begin
                        state_d = keypad_wake_pkg::REQ_ACKED;
                    end
                end
            end
            keypad_wake_pkg::REQ_ACKED: begin
                // (R6) release once all pins high
                if (!any_low || !level_sense_select_q) begin
                    state_d = keypad_wake_pkg::REQ_IDLE;
                end
            end
            default: begin
                state_d = keypad_wake_pkg::REQ_IDLE;
            end
        endcase
        // (R9) new edge after ack relatches, set wins
        if (fall) begin
            state_d = keypad_wake_pkg::REQ_LATCHED;
        end
    end

    // (R12) reset drops the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= keypad_wake_pkg::REQ_IDLE;
        end else if (ce_i) begin
            state_q <= state_d;
        end
    end

    // (R5) level mode holds while any pin low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            request_q <= 1'b0;
        end else if (ce_i) begin
            request_q <= (state_d != keypad_wake_pkg::REQ_IDLE);
        end
    end

    // (R10) unmasked request to cpu
    assign irq_request_o = request_q && !request_mask_q;
    // (R18) (R19) wake from wait or stop
    assign wake_o        = irq_request_o && cpu_ctrl_i.low_power;

endmodule

`default_nettype wire

// >>> keypad_wake_unit_props.sv
// concurrent checks on the keypad wake unit ports
`include "keypad_wake_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module keypad_wake_unit_props #(
    parameter int PINS = 8
) (
    input wire logic                          clk_i,
    input wire logic                          rst_i,
    input wire logic                          ce_i,
    input wire keypad_wake_pkg::wb_req_type   wb_req_i,
    input wire keypad_wake_pkg::wb_rsp_type   wb_rsp_o,
    input wire keypad_wake_pkg::cpu_ctrl_type cpu_ctrl_i,
    input wire logic [PINS-1:0]               port_a_pins_i,
    input wire logic [PINS-1:0]               port_a_direction_i,
    input wire logic [PINS-1:0]               port_a_direction_eff_o,
    input wire logic [PINS-1:0]               pullup_enable_o,
    input wire logic                          irq_request_o,
    input wire logic                          wake_o
);
    logic            tk, wr, sc, allhi, ackev, brk, mode_q, mask_q;
    logic [PINS-1:0] pull_q;
    logic [2:0]      hi_q, lo_q;
    assign tk = ce_i & wb_req_i.cyc & wb_req_i.stb & ~wb_rsp_o.ack;
    assign wr = tk & wb_req_i.we & wb_req_i.sel[0];
    assign sc = wb_req_i.adr == `KPD_STATUS_CONTROL_ADR;
    assign allhi = &(port_a_pins_i | ~pullup_enable_o);
    assign brk = cpu_ctrl_i.in_break & ~cpu_ctrl_i.break_clear_enable;
    assign ackev = ce_i & (cpu_ctrl_i.vector_fetch | (wr & sc & wb_req_i.dat[2] & ~brk));
    ////////////////////////////////////////////////////////////////
    // shadow of mode and mask bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_q <= 1'b0;
            mask_q <= 1'b0;
        end else if (wr && sc) begin
            mode_q <= wb_req_i.dat[0];
            mask_q <= wb_req_i.dat[1];
        end
    end
    // cycles of steady high or low on enabled pins
    always_ff @(posedge clk_i) begin
        pull_q <= pullup_enable_o;
        hi_q <= (rst_i || pull_q != pullup_enable_o || !allhi) ? 3'h0 : hi_q + 3'(hi_q != 3'h7);
        lo_q <= (rst_i || pull_q != pullup_enable_o || allhi || (wr && sc && wb_req_i.dat[0] != mode_q))
                ? 3'h0 : lo_q + 3'(lo_q != 3'h7);
    end
    ////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    dir_override_a: assert property (port_a_direction_eff_o == (port_a_direction_i & ~pullup_enable_o))
        else $error("effective direction wrong");
    wake_follow_a: assert property (wake_o == (irq_request_o && cpu_ctrl_i.low_power))
        else $error("wake output wrong");
    reset_clear_a: assert property ($fell(rst_i) |-> !irq_request_o && pullup_enable_o == '0)
        else $error("reset left request or enables");
    enable_write_a: assert property (wr && wb_req_i.adr == `KPD_PIN_ENABLE_ADR
        |=> pullup_enable_o == $past(wb_req_i.dat[PINS-1:0])) else $error("enable write lost");
    ack_reads_zero_a: assert property (tk && !wb_req_i.we && sc
        |=> wb_rsp_o.ack && wb_rsp_o.dat[7:4] == 4'h0 && !wb_rsp_o.dat[2]) else $error("status read bad");
    mask_gate_a: assert property (irq_request_o |-> !mask_q) else $error("masked request shown");
    ack_clears_a: assert property (ackev && hi_q >= 3'h4 |-> ##[1:2] !irq_request_o)
        else $error("acknowledge did not clear");
    level_hold_a: assert property (mode_q && !mask_q && lo_q >= 3'h5 |-> irq_request_o)
        else $error("level request dropped");
    break_guard_a: assert property (!mode_q && irq_request_o && brk && wr && sc && !wb_req_i.dat[1]
        && !cpu_ctrl_i.vector_fetch |=> irq_request_o) else $error("ack taken during break");
endmodule
`default_nettype wire

// >>> keypad_switch_model.sv
// switches and floating pads on the port a pins
`timescale 1ns/1ns
`default_nettype none
module keypad_switch_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] press_i,
    input  wire logic [7:0] pullup_i,
    output logic      [7:0] pins_o
);
    logic [7:0] float_q = 8'h55;
    // open pads without pullup wander
    always @(posedge clk_i) begin
        float_q <= ~float_q;
    end
    assign pins_o = ~press_i & (pullup_i | float_q);
endmodule
`default_nettype wire

// >>> test_keypad_wake_unit.sv
// self-checking bench for the keypad wake unit
`include "keypad_wake_consts.svh"
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin mismatches++; $display("FAIL t=%0t got %h exp %h", $time, a, e); end end
module test_keypad_wake_unit;
    localparam int         PINS = 8;
    localparam logic [9:0] SC = `KPD_STATUS_CONTROL_ADR;
    localparam logic [9:0] EN = `KPD_PIN_ENABLE_ADR;
    logic                          clk_i, rst_i, ce_i, irq_request_o, wake_o;
    logic [7:0]                    port_a_pins_i, port_a_direction_i, port_a_direction_eff_o, pullup_enable_o, press, r;
    keypad_wake_pkg::wb_req_type   wb_req_i;
    keypad_wake_pkg::wb_rsp_type   wb_rsp_o;
    keypad_wake_pkg::cpu_ctrl_type cpu_ctrl_i;
    int                            mismatches, checked, cycles;
    keypad_wake_unit #(.PINS(PINS)) u_keypad_wake_unit (.clk_i, .rst_i, .ce_i, .wb_req_i, .wb_rsp_o, .cpu_ctrl_i,
        .port_a_pins_i, .port_a_direction_i, .port_a_direction_eff_o, .pullup_enable_o, .irq_request_o, .wake_o);
    keypad_switch_model u_switches (.clk_i, .press_i(press), .pullup_i(pullup_enable_o), .pins_o(port_a_pins_i));
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////
    function automatic logic [7:0] sc_exp(input logic pend, input logic mask, input logic mode);
        return {4'h0, pend, 1'b0, mask, mode};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic bus(input logic we, input logic [9:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_i);
        wb_req_i <= {a, 24'h0, d, 4'hF, we, 2'b11};
        do @(posedge clk_i); while (wb_rsp_o.ack !== 1'b1);
        q = wb_rsp_o.dat[7:0];
        wb_req_i <= '0;
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [9:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        `CHK(q, e)
    endtask
    task automatic vf();
        @(posedge clk_i);
        cpu_ctrl_i.vector_fetch <= 1'b1;
        @(posedge clk_i);
        cpu_ctrl_i.vector_fetch <= 1'b0;
        tick(2);
    endtask
    task automatic summarize();
        if (mismatches == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(92167));
        mismatches = 0;
        checked = 0;
        cycles = 0;
        {rst_i, ce_i, wb_req_i, cpu_ctrl_i, press, port_a_direction_i} = {2'b11, 49'h0, 4'h0, 16'h0};
        tick(5);
        rst_i <= 1'b0;
        rdc(SC, 8'h00);
        rdc(EN, 8'h00);
        rdc(10'h3FC, 8'h00);
        r = 8'($urandom);
        port_a_direction_i <= 8'($urandom);
        wr(EN, r);
        rdc(EN, r);
        wr(SC, 8'h02);
        wr(EN, 8'h0F);
        wr(SC, 8'h06);
        wr(SC, 8'h00);
        press <= 8'h01;
        tick(4);
        rdc(SC, sc_exp(1'b1, 1'b0, 1'b0));
        press <= 8'h03;
        wr(SC, 8'h04);
        tick(4);
        `CHK(irq_request_o, 1'b0)
        press <= 8'h20;
        tick(4);
        `CHK(irq_request_o, 1'b0)
        press <= 8'h24;
        tick(4);
        `CHK(irq_request_o, 1'b1)
        vf();
        `CHK(irq_request_o, 1'b0)
        press <= 8'h00;
        tick(4);
        press <= 8'h08;
        tick(4);
        `CHK(irq_request_o, 1'b1)
        ce_i <= 1'b0;
        vf();
        `CHK(irq_request_o, 1'b1)
        ce_i <= 1'b1;
        wr(SC, 8'h06);
        press <= 8'h00;
        tick(4);
        press <= 8'h08;
        tick(4);
        rdc(SC, sc_exp(1'b1, 1'b1, 1'b0));
        `CHK(irq_request_o, 1'b0)
        cpu_ctrl_i.low_power <= 1'b1;
        wr(SC, 8'h00);
        `CHK(wake_o, 1'b1)
        cpu_ctrl_i.in_break <= 1'b1;
        wr(SC, 8'h04);
        tick(2);
        `CHK(irq_request_o, 1'b1)
        cpu_ctrl_i.break_clear_enable <= 1'b1;
        wr(SC, 8'h04);
        tick(2);
        `CHK(irq_request_o, 1'b0)
        cpu_ctrl_i <= '0;
        press <= 8'h00;
        wr(SC, 8'h05);
        press <= 8'h01;
        tick(4);
        `CHK(irq_request_o, 1'b1)
        wr(SC, 8'h05);
        tick(4);
        `CHK(irq_request_o, 1'b1)
        press <= 8'h00;
        tick(4);
        `CHK(irq_request_o, 1'b0)
        press <= 8'h01;
        tick(4);
        press <= 8'h00;
        tick(4);
        `CHK(irq_request_o, 1'b1)
        vf();
        `CHK(irq_request_o, 1'b0)
        press <= 8'h01;
        tick(4);
        rst_i <= 1'b1;
        tick(1);
        rst_i <= 1'b0;
        tick(1);
        `CHK(irq_request_o, 1'b0)
        rdc(SC, 8'h00);
        summarize();
    end
endmodule
bind keypad_wake_unit keypad_wake_unit_props #(.PINS(PINS)) u_props (.clk_i, .rst_i, .ce_i, .wb_req_i, .wb_rsp_o,
    .cpu_ctrl_i, .port_a_pins_i, .port_a_direction_i, .port_a_direction_eff_o, .pullup_enable_o, .irq_request_o, .wake_o);
`default_nettype wire
